//--- hw/gsp_regs.vh
// Constants for the gripper status and picking block: byte offsets,
// field positions, encodings, reset values and re-grasp tuning.
// Assumes inclusion by bare name from the block's design files.
`ifndef GSP_REGS_VH
`define GSP_REGS_VH

// Command bank byte offsets (written by the controller)
`define GSP_CMD_ACTION 4'h0
`define GSP_CMD_TARGET 4'h3
`define GSP_CMD_SPEED 4'h4
`define GSP_CMD_FORCE 4'h5

// Status bank byte offsets (read by the controller)
`define GSP_STS_GRIPPER 4'h0
`define GSP_STS_RESERVED 4'h1
`define GSP_STS_FAULT 4'h2
`define GSP_STS_TARGET_ECHO 4'h3
`define GSP_STS_FINGER_POS 4'h4
`define GSP_STS_CURRENT 4'h5

// Field positions
`define GSP_MOVE_REQUEST_BIT 3
`define GSP_OBJ_LSB 6

// Object status encodings
`define GSP_OBJ_MOVING 2'h0
`define GSP_OBJ_CONTACT_OPEN 2'h1
`define GSP_OBJ_CONTACT_CLOSE 2'h2
`define GSP_OBJ_AT_TARGET 2'h3

// Reset values
`define GSP_RST_BYTE 8'h00
`define GSP_RST_OBJ 2'h0

// Force handling: zero request disables re-grasp and uses the floor limit
`define GSP_FORCE_OFF 8'h00
`define GSP_MIN_FORCE_LIMIT 8'h08

// Re-grasp automatic settings before capping by the last request
`define GSP_REGRASP_AUTO_SPEED 8'h40
`define GSP_REGRASP_AUTO_FORCE 8'hC0

`endif

//--- hw/gsp_cap.v
// Caps an automatically chosen setting at a requested ceiling.
// Assumes both operands are unsigned values of the same width.
`timescale 1ns/10ps

module gsp_cap #(
  parameter WIDTH = 8
) (
  // Values to compare
  input wire [WIDTH-1:0] i_auto,
  input wire [WIDTH-1:0] i_ceiling,
  // Capped result
  output wire [WIDTH-1:0] o_value
);

  // Never exceed the ceiling
  assign o_value = (i_auto > i_ceiling) ? i_ceiling : i_auto;

endmodule // gsp_cap

//--- hw/gsp_core.v
// Gripper picking control with status readback bytes.
// Assumes synchronous byte-wide command writes and status reads, an
// encoder position and a drive current sample updated in the same clock.
`timescale 1ns/10ps
`include "gsp_regs.vh"

// Overview of operation
// - Status byte three echoes last requested target, 00 open, FF closed.
// - Status byte four shows encoder finger position, 00 open, FF closed.
// - Status byte five shows instantaneous drive current, ten mA per count.
// - Force zero disables re-grasp with a fixed limit of 08; one to 255 enables it.
// - Re-grasp restarts closing on its own when a held object slips.
// - Re-grasp stops at the requested position even without an object.
// - Re-grasp picks its own force and speed, capped at requested values.
// - Object status clears whenever finger motion is detected, except at target.
// - Object status: 0 moving, 1 contact opening, 2 contact closing, 3 target.
// - After move request, status reads 08 while moving, 88 on closing contact.
// - Gripper status carries an echo of the move request bit.
// - Current above force limit stops fingers and flags object detection.
module gsp_core (
  // Clock, reset and enable
  input wire i_clock,
  input wire i_nrst,
  input wire i_clk_en,
  // Command byte write port
  input wire i_wr_en,
  input wire [3:0] i_wr_addr,
  input wire [7:0] i_wr_data,
  // Status byte read port
  input wire i_rd_en,
  input wire [3:0] i_rd_addr,
  output reg [7:0] o_rd_data,
  output reg o_rd_valid,
  // Drive feedback
  input wire [7:0] i_finger_position,
  input wire [7:0] i_drive_current,
  // Drive commands
  output reg o_motor_run,
  output reg o_motor_close,
  output reg [7:0] o_speed_cmd,
  output reg [7:0] o_current_limit
);

  // Motion states
  localparam ST_IDLE = 3'd0;
  localparam ST_MOVE = 3'd1;
  localparam ST_CONTACT_OPEN = 3'd2;
  localparam ST_CONTACT_CLOSE = 3'd3;
  localparam ST_AT_TARGET = 3'd4;
  localparam ST_REGRASP = 3'd5;

  // Command registers
  reg move_request_ff;
  reg [7:0] target_position_ff;
  reg [7:0] speed_setting_ff;
  reg [7:0] force_setting_ff;
  reg [7:0] target_echo_ff;
  // Feedback samples
  reg [7:0] finger_position_ff;
  reg [7:0] drive_current_ff;
  reg [7:0] prev_position_ff;
  // Motion and status
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [1:0] object_status_ff;
  reg [1:0] nxt_object_status;
  reg nxt_motor_run;
  reg nxt_motor_close;
  reg [7:0] nxt_speed_cmd;
  reg [7:0] nxt_current_limit;
  reg [7:0] nxt_rd_data;

  wire regrasp_on;
  wire [7:0] force_limit;
  wire [7:0] regrasp_speed;
  wire [7:0] regrasp_force;
  wire at_target;
  wire need_close;
  wire over_limit;
  wire slipping;
  wire fingers_moved;
  wire target_write;
  wire go_write;
  wire start_move;

  // Force handling and re-grasp enable
  assign regrasp_on = (force_setting_ff != `GSP_FORCE_OFF);
  assign force_limit = regrasp_on ? force_setting_ff : `GSP_MIN_FORCE_LIMIT;

  // Re-grasp settings capped at the last requested values
  gsp_cap #(
    .WIDTH(8)
  ) u_cap_speed (
    .i_auto(`GSP_REGRASP_AUTO_SPEED),
    .i_ceiling(speed_setting_ff),
    .o_value(regrasp_speed)
  );

  gsp_cap #(
    .WIDTH(8)
  ) u_cap_force (
    .i_auto(`GSP_REGRASP_AUTO_FORCE),
    .i_ceiling(force_limit),
    .o_value(regrasp_force)
  );

  // Motion conditions from sampled feedback
  assign at_target = (finger_position_ff == target_position_ff);
  assign need_close = (target_position_ff > finger_position_ff);
  assign over_limit = (drive_current_ff > o_current_limit);
  // Grip lost: current falls well below the hold limit while holding
  assign slipping = (drive_current_ff < {1'b0, force_limit[7:1]});
  assign fingers_moved = (finger_position_ff != prev_position_ff);

  // Command writes that start a new motion
  assign target_write = i_wr_en && (i_wr_addr == `GSP_CMD_TARGET);
  assign go_write = i_wr_en && (i_wr_addr == `GSP_CMD_ACTION) &&
                    i_wr_data[`GSP_MOVE_REQUEST_BIT] && !move_request_ff;
  assign start_move = go_write || (target_write && move_request_ff);

  // Command bank and target echo; other status bytes live elsewhere and take no writes
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      move_request_ff <= 1'b0;
      target_position_ff <= `GSP_RST_BYTE;
      speed_setting_ff <= `GSP_RST_BYTE;
      force_setting_ff <= `GSP_RST_BYTE;
      target_echo_ff <= `GSP_RST_BYTE;
    end else if (i_clk_en && i_wr_en) begin
      case (i_wr_addr)
        `GSP_CMD_ACTION: begin
          move_request_ff <= i_wr_data[`GSP_MOVE_REQUEST_BIT];
        end
        `GSP_CMD_TARGET: begin
          target_position_ff <= i_wr_data;
          target_echo_ff <= i_wr_data;
        end
        `GSP_CMD_SPEED: begin
          speed_setting_ff <= i_wr_data;
        end
        `GSP_CMD_FORCE: begin
          force_setting_ff <= i_wr_data;
        end
        default: begin
          move_request_ff <= move_request_ff;
        end
      endcase
    end
  end

  // Feedback sampling
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      finger_position_ff <= `GSP_RST_BYTE;
      drive_current_ff <= `GSP_RST_BYTE;
      prev_position_ff <= `GSP_RST_BYTE;
    end else if (i_clk_en) begin
      finger_position_ff <= i_finger_position;
      drive_current_ff <= i_drive_current;
      prev_position_ff <= finger_position_ff;
    end
  end

  // Motion state machine and drive commands
  always @* begin
    nxt_state = state_ff;
    nxt_motor_run = 1'b0;
    nxt_motor_close = o_motor_close;
    nxt_speed_cmd = speed_setting_ff;
    nxt_current_limit = force_limit;
    case (state_ff)
      ST_IDLE: begin
        if (start_move) begin
          nxt_state = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (at_target) begin
          nxt_state = ST_AT_TARGET;
        end else if (over_limit) begin
          nxt_state = o_motor_close ? ST_CONTACT_CLOSE : ST_CONTACT_OPEN;
        end else begin
          nxt_motor_run = 1'b1;
          nxt_motor_close = need_close;
        end
      end
      ST_CONTACT_CLOSE: begin
        if (regrasp_on && slipping) begin
          nxt_state = ST_REGRASP;
        end
      end
      ST_CONTACT_OPEN: begin
        nxt_state = ST_CONTACT_OPEN;
      end
      ST_AT_TARGET: begin
        nxt_state = ST_AT_TARGET;
      end
      ST_REGRASP: begin
        nxt_speed_cmd = regrasp_speed;
        nxt_current_limit = regrasp_force;
        if (at_target || !need_close) begin
          nxt_state = ST_AT_TARGET;
        end else if (over_limit) begin
          nxt_state = ST_CONTACT_CLOSE;
        end else begin
          nxt_motor_run = 1'b1;
          nxt_motor_close = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // A new request restarts, a cleared request stops
    if (!move_request_ff && !go_write) begin
      nxt_state = ST_IDLE;
      nxt_motor_run = 1'b0;
    end else if (start_move && state_ff != ST_IDLE) begin
      nxt_state = ST_MOVE;
    end
  end

  // Object status from state, cleared while fingers move unless at target
  always @* begin
    case (nxt_state)
      ST_CONTACT_OPEN: begin
        nxt_object_status = `GSP_OBJ_CONTACT_OPEN;
      end
      ST_CONTACT_CLOSE: begin
        nxt_object_status = `GSP_OBJ_CONTACT_CLOSE;
      end
      ST_AT_TARGET: begin
        nxt_object_status = `GSP_OBJ_AT_TARGET;
      end
      default: begin
        nxt_object_status = `GSP_OBJ_MOVING;
      end
    endcase
    if (fingers_moved && nxt_state != ST_AT_TARGET) begin
      nxt_object_status = `GSP_OBJ_MOVING;
    end
  end

  // Motion registers
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
      object_status_ff <= `GSP_RST_OBJ;
      o_motor_run <= 1'b0;
      o_motor_close <= 1'b0;
      o_speed_cmd <= `GSP_RST_BYTE;
      o_current_limit <= `GSP_MIN_FORCE_LIMIT;
    end else if (i_clk_en) begin
      state_ff <= nxt_state;
      object_status_ff <= nxt_object_status;
      o_motor_run <= nxt_motor_run;
      o_motor_close <= nxt_motor_close;
      o_speed_cmd <= nxt_speed_cmd;
      o_current_limit <= nxt_current_limit;
    end
  end

  // Status byte decode; unmapped bytes read zero
  always @* begin
    case (i_rd_addr)
      `GSP_STS_GRIPPER: begin
        nxt_rd_data = {object_status_ff, 2'h0, move_request_ff, 3'h0};
      end
      `GSP_STS_TARGET_ECHO: begin
        nxt_rd_data = target_echo_ff;
      end
      `GSP_STS_FINGER_POS: begin
        nxt_rd_data = finger_position_ff;
      end
      `GSP_STS_CURRENT: begin
        nxt_rd_data = drive_current_ff;
      end
      default: begin
        nxt_rd_data = `GSP_RST_BYTE;
      end
    endcase
  end

  // Registered read answer
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rd_data <= `GSP_RST_BYTE;
      o_rd_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= nxt_rd_data;
      end
    end
  end

endmodule // gsp_core

//--- test/gsp_core_props.sv
// Checker for the gripper status block, bound to gsp_core.
// Assumes one clock domain; command bytes are shadowed here.
`timescale 1ns/10ps
`include "gsp_regs.vh"
module gsp_core_props (
  // Clock and reset
  input wire i_clock,
  input wire i_nrst,
  input wire i_clk_en,
  // Byte ports
  input wire i_wr_en,
  input wire [3:0] i_wr_addr,
  input wire [7:0] i_wr_data,
  input wire i_rd_en,
  input wire [3:0] i_rd_addr,
  input wire [7:0] o_rd_data,
  input wire o_rd_valid,
  // Drive side
  input wire [7:0] i_finger_position,
  input wire [7:0] i_drive_current,
  input wire o_motor_run,
  input wire [7:0] o_speed_cmd,
  input wire [7:0] o_current_limit
);
  reg [7:0] tgt_ff;
  reg [7:0] spd_ff;
  reg [7:0] frc_ff;
  reg req_ff;
  wire wr = i_clk_en & i_wr_en;
  wire rd = i_clk_en & i_rd_en;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  // Shadow of the command bytes
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      tgt_ff <= 8'h00;
      spd_ff <= 8'h00;
      frc_ff <= 8'h00;
      req_ff <= 1'b0;
    end else if (wr) begin
      case (i_wr_addr)
        `GSP_CMD_TARGET: tgt_ff <= i_wr_data;
        `GSP_CMD_SPEED: spd_ff <= i_wr_data;
        `GSP_CMD_FORCE: frc_ff <= i_wr_data;
        `GSP_CMD_ACTION: req_ff <= i_wr_data[`GSP_MOVE_REQUEST_BIT];
        default: ;
      endcase
    end
  end
  read_pulse_a: assert property (
    o_rd_valid == $past(rd)) else $error("read valid wrong");
  echo_read_a: assert property (
    rd && i_rd_addr == `GSP_STS_TARGET_ECHO |=> o_rd_data == $past(tgt_ff))
    else $error("target echo wrong");
  pos_read_a: assert property (
    rd && i_rd_addr == `GSP_STS_FINGER_POS |=> o_rd_data == $past(i_finger_position, 2))
    else $error("position read wrong");
  cur_read_a: assert property (
    rd && i_rd_addr == `GSP_STS_CURRENT |=> o_rd_data == $past(i_drive_current, 2))
    else $error("current read wrong");
  move_echo_a: assert property (
    rd && i_rd_addr == `GSP_STS_GRIPPER |=> o_rd_data[5:0] == {2'b00, $past(req_ff), 3'b000})
    else $error("status byte wrong");
  move_start_a: assert property (
    wr && i_wr_addr == `GSP_CMD_ACTION && i_wr_data[`GSP_MOVE_REQUEST_BIT] && !req_ff
    && tgt_ff != i_finger_position |-> ##[1:4] o_motor_run) else $error("move not started");
  force_floor_a: assert property (
    o_motor_run && frc_ff == `GSP_FORCE_OFF |-> o_current_limit == `GSP_MIN_FORCE_LIMIT)
    else $error("floor limit wrong");
  drive_cap_a: assert property (
    o_motor_run |-> o_speed_cmd <= spd_ff
    && (frc_ff == `GSP_FORCE_OFF || o_current_limit <= frc_ff)) else $error("cap exceeded");
  contact_stop_a: assert property (
    o_motor_run && i_drive_current > o_current_limit |-> ##[1:3] !o_motor_run)
    else $error("no stop on contact");
endmodule // gsp_core_props
bind gsp_core gsp_core_props u_chk (.i_clock, .i_nrst, .i_clk_en, .i_wr_en, .i_wr_addr,
  .i_wr_data, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_valid, .i_finger_position,
  .i_drive_current, .o_motor_run, .o_speed_cmd, .o_current_limit);

//--- test/gsp_finger_model.sv
// Finger mechanics: one count every four cycles while driven.
// Assumes drive commands from gsp_core and an object edge from the bench.
`timescale 1ns/10ps
module gsp_finger_model (
  // Clock and drive commands
  input wire i_clock,
  input wire i_run,
  input wire i_close,
  // Object edge, 00 for none
  input wire [7:0] i_obj_at,
  // Feedback
  output reg [7:0] o_pos,
  output wire [7:0] o_cur
);
  reg [1:0] div_ff = 2'h0;
  wire press = (i_obj_at != 8'h00) && (o_pos >= i_obj_at);
  // Holding current on an object, running current while driven, zero when idle
  assign o_cur = press ? 8'hF0 : (i_run ? 8'h10 : 8'h00);
  initial o_pos = 8'h00;
  // Slow steps so the stop lands before the next count
  always @(posedge i_clock) begin
    div_ff <= div_ff + 2'h1;
    if (div_ff == 2'h3 && i_run && i_close && !press && o_pos != 8'hFF) begin
      o_pos <= o_pos + 8'h01;
    end else if (div_ff == 2'h3 && i_run && !i_close && o_pos != 8'h00) begin
      o_pos <= o_pos - 8'h01;
    end
  end
endmodule // gsp_finger_model

//--- test/gsp_core_bench.sv
// Self-checking bench: command writes, status reads, grasp sequences.
// Assumes gsp_core, the finger model and the bound checker.
`timescale 1ns/10ps
module gsp_core_bench;
  reg i_clock = 1'b0;
  reg i_nrst = 1'b0;
  reg i_clk_en = 1'b1;
  reg i_wr_en = 1'b0;
  reg [3:0] i_wr_addr = 4'h0;
  reg [7:0] i_wr_data = 8'h00;
  reg i_rd_en = 1'b0;
  reg [3:0] i_rd_addr = 4'h0;
  reg [7:0] obj_at = 8'h00;
  wire [7:0] pos, cur, rd_data, spd, lim;
  wire rd_valid, run, dir;
  integer fail_count = 0;
  integer cmp_count = 0;
  always #2 i_clock = ~i_clock;
  gsp_core uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_clk_en(i_clk_en), .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_finger_position(pos),
    .i_drive_current(cur), .o_motor_run(run), .o_motor_close(dir), .o_speed_cmd(spd),
    .o_current_limit(lim));
  gsp_finger_model fm (.i_clock(i_clock), .i_run(run), .i_close(dir), .i_obj_at(obj_at),
    .o_pos(pos), .o_cur(cur));
  // Compare and count
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // One command byte write
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(negedge i_clock);
      i_wr_en = 1'b1;
      i_wr_addr = a;
      i_wr_data = d;
      @(negedge i_clock);
      i_wr_en = 1'b0;
    end
  endtask
  // One status byte read, answered one cycle later
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(negedge i_clock);
      i_rd_en = 1'b1;
      i_rd_addr = a;
      @(negedge i_clock);
      i_rd_en = 1'b0;
      chk("rd_valid", {7'h00, rd_valid}, 8'h01);
      chk("rd_data", rd_data, e);
    end
  endtask
  // Bounded wait for the drive to reach a level
  task wt(input lvl);
    integer n;
    begin
      n = 0;
      while (run !== lvl && n < 400) begin
        @(negedge i_clock);
        n = n + 1;
      end
      chk("motor_run", {7'h00, run}, {7'h00, lvl});
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  // Watchdog well past the expected run
  initial begin
    #20000;
    fail_count = fail_count + 1;
    close_out;
  end
  // Test sequence
  initial begin
    repeat (4) @(negedge i_clock);
    i_nrst = 1'b1;
    wr(4'h3, 8'h40);
    wr(4'h4, 8'h90);
    wr(4'h5, 8'h80);
    wr(4'h6, 8'hAA);
    rd(4'h3, 8'h40);
    rd(4'h1, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'h5, 8'h00);
    $display("test registers done");
    obj_at = 8'h20;
    wr(4'h0, 8'h08);
    wt(1'b1);
    chk("motor_close", {7'h00, dir}, 8'h01);
    chk("speed_cmd", spd, 8'h90);
    rd(4'h0, 8'h08);
    wt(1'b0);
    rd(4'h0, 8'h88);
    rd(4'h4, 8'h20);
    rd(4'h5, 8'hF0);
    $display("test grasp done");
    obj_at = 8'h00;
    wt(1'b1);
    repeat (2) @(negedge i_clock);
    chk("speed_cmd", spd, 8'h40);
    chk("current_limit", lim, 8'h80);
    wt(1'b0);
    rd(4'h0, 8'hC8);
    rd(4'h4, 8'h40);
    $display("test regrasp done");
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    wr(4'h5, 8'h00);
    wr(4'h3, 8'h10);
    wr(4'h0, 8'h08);
    wt(1'b1);
    chk("motor_close", {7'h00, dir}, 8'h00);
    chk("current_limit", lim, 8'h08);
    wt(1'b0);
    // Let a last finger step after the stop settle out of the status
    repeat (4) @(negedge i_clock);
    rd(4'h0, 8'h48);
    repeat (20) @(negedge i_clock);
    chk("motor_run", {7'h00, run}, 8'h00);
    $display("test zero force done");
    // A write while the enable is low must leave the target byte untouched
    i_clk_en = 1'b0;
    wr(4'h3, 8'h77);
    i_clk_en = 1'b1;
    rd(4'h3, 8'h10);
    $display("test clock enable done");
    close_out;
  end
endmodule // gsp_core_bench
